// file: hdl/sram_host_pkg.sv
// Package with timing counts and field constants for the async SRAM host controller
package sram_host_pkg;
  // Clock period in ns
  localparam int CLK_PERIOD_NS = 100;
  // Device timing figures in ns
  localparam int T_RC_NS = 70;
  localparam int T_WP_NS = 50;
  localparam int T_AS_NS = 0;
  localparam int T_WR_NS = 0;
  localparam int T_OH_NS = 10;
  localparam int T_SDR_NS = 0;
  // Cycle counts: least times round up, never below one cycle
  localparam int RC_CYC_I = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC_I = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RC_CYC = (RC_CYC_I < 1) ? 4'h1 : RC_CYC_I[3:0];
  localparam logic [3:0] WP_CYC = (WP_CYC_I < 1) ? 4'h1 : WP_CYC_I[3:0];
  // Recovery after supply restore equals one read cycle
  localparam logic [3:0] RDR_CYC = RC_CYC;
  // Data bus widths and lanes
  localparam int DATA_W = 16;
  localparam int ADDR_W = 20;
  localparam int LANE_LO_MSB = 7;
  localparam int LANE_HI_LSB = 8;
  // Reset value of the count register
  localparam logic [3:0] CNT_RESET = 4'h0;
endpackage

// file: hdl/sram_host.sv
// Host controller that drives an asynchronous 1M x 16 SRAM through its pins
// Function
// - Write happens only while low select and write strobe low, high select high.
// - Single byte write asserts exactly one lane enable; other lane undriven.
// - Word write asserts both lane enables together; all sixteen bits stored.
// - Host drives every strobe and address to a valid level, never floating.
// - Deselect before lowering supply; wait one read cycle after recovery.
module sram_host #(
  parameter int DATA_W = sram_host_pkg::DATA_W,
  parameter int ADDR_W = sram_host_pkg::ADDR_W
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  // User request side
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  input wire logic [1:0] REQ_LANES,
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_RDATA,
  // Retention control
  input wire logic RETAIN_REQ,
  output logic RETAIN_SAFE,
  input wire logic SUPPLY_OK,
  // SRAM pins
  output logic [ADDR_W-1:0] SRAM_ADDR,
  output logic SRAM_CS_N,
  output logic SRAM_CS_HI,
  output logic SRAM_OE_N,
  output logic SRAM_WE_N,
  output logic SRAM_LB_N,
  output logic SRAM_UB_N,
  input wire logic [DATA_W-1:0] SRAM_DQ_I,
  output logic [DATA_W-1:0] SRAM_DQ_O,
  output logic [DATA_W-1:0] SRAM_DQ_OE
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD = 3'b001,
    ST_WR = 3'b010,
    ST_WEND = 3'b011,
    ST_RET = 3'b100,
    ST_RCV = 3'b101
  } state_e;

  state_e state_r;
  state_e state_nxt;
  logic [3:0] cnt_r;
  logic [DATA_W-1:0] dq_s1_r;
  logic [DATA_W-1:0] dq_s2_r;
  logic sup_s1_r;
  logic sup_s2_r;
  logic [1:0] lanes_r;
  logic cnt_done;
  logic take;

  // Width of the lower lane; the upper lane takes the remaining data bits
  localparam int LANE_HI = sram_host_pkg::LANE_HI_LSB;

  assign cnt_done = (cnt_r <= 4'h1);
  // A request with no lane selected would only deselect the part, so it is not taken
  assign take = REQ_VALID && (REQ_LANES != 2'b00) && !RETAIN_REQ;
  assign REQ_READY = (state_r == ST_IDLE) && !RETAIN_REQ;
  assign RETAIN_SAFE = (state_r == ST_RET);

  // Two-stage synchroniser for the data pins
  // The part answers with no clock of its own, so its data may change near our edge
  always_ff @(posedge SYS_CLK) begin
    dq_s1_r <= SRAM_DQ_I;
    dq_s2_r <= dq_s1_r;
  end

  // Two-stage synchroniser for the supply status
  // Only the second stage is read, so a slow supply edge cannot upset the state machine
  always_ff @(posedge SYS_CLK) begin
    sup_s1_r <= SUPPLY_OK;
    sup_s2_r <= sup_s1_r;
  end

  // Next state decode
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (RETAIN_REQ) begin
          state_nxt = ST_RET;
        end else if (take) begin
          state_nxt = REQ_WRITE ? ST_WR : ST_RD;
        end
      end
      // Read held two extra cycles for the two sync stages so sampled data reflects the settled pins
      ST_RD: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      // Write strobe stays low for the whole write pulse count
      ST_WR: begin
        if (cnt_done) begin
          state_nxt = ST_WEND;
        end
      end
      // One cycle with the strobe high but data still driven
      ST_WEND: begin
        state_nxt = ST_IDLE;
      end
      // Leave retention only once the restored supply has been seen twice
      ST_RET: begin
        if (!RETAIN_REQ && sup_s2_r) begin
          state_nxt = ST_RCV;
        end
      end
      // Recovery wait of one read cycle before any new access
      ST_RCV: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Phase counter; reads wait a full cycle time plus the two sync stages
  // Loaded on the take edge, counts down to one and then rests there
  // Rounding every least time up trades a little speed for margin at any clock rate
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cnt_r <= sram_host_pkg::CNT_RESET;
    end else if (state_r == ST_IDLE && take) begin
      cnt_r <= REQ_WRITE ? sram_host_pkg::WP_CYC : sram_host_pkg::RC_CYC + 4'h2;
    end else if (state_r == ST_RET && state_nxt == ST_RCV) begin
      cnt_r <= sram_host_pkg::RDR_CYC;
    end else if (!cnt_done) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Pin drive: every strobe always at a defined level
  // All pins come from flip-flops so the part never sees a combinational glitch
  // Write: low select, lanes and strobe fall as high select rises, strobe rises a pulse later,
  // selects and lanes return to idle one cycle after that
  // Read: low select, lanes and output enable fall as high select rises, and stay until the
  // synchronised data has been captured
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      SRAM_ADDR <= '0;
      SRAM_CS_N <= 1'b1;
      SRAM_CS_HI <= 1'b0;
      SRAM_OE_N <= 1'b1;
      SRAM_WE_N <= 1'b1;
      SRAM_LB_N <= 1'b1;
      SRAM_UB_N <= 1'b1;
      SRAM_DQ_O <= '0;
      lanes_r <= 2'b00;
    end else if (state_r == ST_IDLE && take && !RETAIN_REQ) begin
      // Address, selects and lanes set together; address setup is zero
      SRAM_ADDR <= REQ_ADDR;
      SRAM_CS_N <= 1'b0;
      SRAM_CS_HI <= 1'b1;
      SRAM_LB_N <= !REQ_LANES[0];
      SRAM_UB_N <= !REQ_LANES[1];
      SRAM_OE_N <= REQ_WRITE;
      SRAM_WE_N <= !REQ_WRITE;
      SRAM_DQ_O <= REQ_WDATA;
      lanes_r <= REQ_LANES;
    end else if (state_r == ST_WR && cnt_done) begin
      // WE rises first and ends the write while data still stands
      SRAM_WE_N <= 1'b1;
    end else if ((state_r == ST_RD && cnt_done) || state_r == ST_WEND) begin
      // Deselect with both selects; lanes left idle high
      SRAM_CS_N <= 1'b1;
      SRAM_CS_HI <= 1'b0;
      SRAM_OE_N <= 1'b1;
      SRAM_LB_N <= 1'b1;
      SRAM_UB_N <= 1'b1;
      lanes_r <= 2'b00;
    end else if (state_nxt == ST_RET) begin
      SRAM_CS_N <= 1'b1;
      SRAM_CS_HI <= 1'b0;
    end
  end

  // Data enable per lane: only during the write and its one-cycle hold after WE rises
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      SRAM_DQ_OE <= '0;
    end else if (state_r == ST_IDLE && take && REQ_WRITE) begin
      SRAM_DQ_OE <= {{(DATA_W-LANE_HI){REQ_LANES[1]}}, {LANE_HI{REQ_LANES[0]}}};
    end else if (state_r == ST_WEND) begin
      SRAM_DQ_OE <= '0; // Released after WE high so data hold time is met
    end
  end

  // Read capture: unselected lane reads as zero since the device floats it
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
    end else begin
      RSP_VALID <= (state_r == ST_RD) && cnt_done;
      if (state_r == ST_RD && cnt_done) begin
        RSP_RDATA <= dq_s2_r & {{(DATA_W-LANE_HI){lanes_r[1]}}, {LANE_HI{lanes_r[0]}}};
      end
    end
  end
endmodule

// file: testbench/sram_host_assertions.sv
// Pin side and user side assertions for the async SRAM host controller
module sram_host_assertions (
  input wire logic SYS_CLK, RESET, REQ_VALID, REQ_READY, REQ_WRITE, RSP_VALID, RETAIN_SAFE,
  input wire logic SRAM_CS_N, SRAM_CS_HI, SRAM_OE_N, SRAM_WE_N, SRAM_LB_N, SRAM_UB_N,
  input wire logic [1:0] REQ_LANES, input wire logic [15:0] SRAM_DQ_OE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire take = REQ_VALID && REQ_READY && REQ_LANES != 2'h0; // Lanes 00 is never taken
  chk_write_sel: assert property (!SRAM_WE_N |-> !SRAM_CS_N && SRAM_CS_HI)
    else $error("unselected write");
  chk_write_lane: assert property (!SRAM_WE_N |-> !SRAM_LB_N || !SRAM_UB_N)
    else $error("write without lane");
  chk_low_drive: assert property (|SRAM_DQ_OE[7:0] |-> !SRAM_LB_N) else $error("low");
  chk_up_drive: assert property (|SRAM_DQ_OE[15:8] |-> !SRAM_UB_N) else $error("up");
  chk_no_clash: assert property (|SRAM_DQ_OE |-> SRAM_OE_N) else $error("clash");
  chk_write_pulse: assert property (take && REQ_WRITE |=> !SRAM_WE_N ##1 SRAM_WE_N
    ##1 SRAM_CS_N) else $error("bad write pulse");
  chk_read_wait: assert property (take && !REQ_WRITE |=> !RSP_VALID[*3] ##1 RSP_VALID)
    else $error("bad read wait");
  chk_resp_once: assert property (RSP_VALID |=> !RSP_VALID) else $error("long rsp");
  chk_retain_off: assert property (RETAIN_SAFE |-> SRAM_CS_N && !SRAM_CS_HI)
    else $error("retain selected");
endmodule

// file: testbench/sram_model.sv
// Behavioural async SRAM device facing the host controller
module sram_model (
  input wire logic [3:0] addr,
  input wire logic cs_n, cs_hi, oe_n, we_n, lb_n, ub_n,
  input wire logic [15:0] dq,
  output logic [15:0] q, q_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16]; // Sixteen words only, address aliases above that
  wire wr = !cs_n && cs_hi && !we_n;
  wire rd = !cs_n && cs_hi && !oe_n && we_n;
  always @(negedge wr) begin // Store as select or strobe rises
    if (!lb_n) mem[addr][7:0] = dq[7:0];
    if (!ub_n) mem[addr][15:8] = dq[15:8];
  end
  assign q = mem[addr]; // Zero delay, turn-off never lags turn-on
  assign q_oe = {{8{rd && !ub_n}}, {8{rd && !lb_n}}};
endmodule

// file: testbench/tb.sv
// Self-checking bench for the async SRAM host controller
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK = 1'b0, RESET = 1'b1, REQ_VALID = 1'b0, REQ_WRITE = 1'b0, RETAIN_REQ = 1'b0;
  logic SUPPLY_OK = 1'b1, REQ_READY, RSP_VALID, RETAIN_SAFE, SRAM_CS_N, SRAM_CS_HI;
  logic SRAM_OE_N, SRAM_WE_N, SRAM_LB_N, SRAM_UB_N;
  logic [1:0] REQ_LANES = 2'h0;
  logic [19:0] REQ_ADDR = 20'h00000, SRAM_ADDR;
  logic [15:0] REQ_WDATA = 16'h0000, RSP_RDATA, SRAM_DQ_O, SRAM_DQ_OE, SRAM_DQ_I, q, q_oe;
  int miscompares = 0, samples_checked = 0, n;
  always #50 SYS_CLK = ~SYS_CLK;
  assign SRAM_DQ_I = (SRAM_DQ_OE & SRAM_DQ_O) | (q_oe & q)
    | (~(SRAM_DQ_OE | q_oe) & (16'hA5A5 ^ {16{SYS_CLK}})); // Idle bits flip, no stale data
  sram_host sram_host_i (.*);
  sram_model sram_model_i (.addr(SRAM_ADDR[3:0]), .cs_n(SRAM_CS_N), .cs_hi(SRAM_CS_HI),
    .oe_n(SRAM_OE_N), .we_n(SRAM_WE_N), .lb_n(SRAM_LB_N), .ub_n(SRAM_UB_N), .dq(SRAM_DQ_I), .q(q), .q_oe(q_oe));
  task automatic check(logic ok);
    samples_checked++;
    miscompares += (ok !== 1'b1);
    if (ok !== 1'b1) $display("mismatch at %0t ns", $time);
  endtask
  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic req(logic w, logic [19:0] a, logic [15:0] d, logic [1:0] l);
    {REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_WDATA, REQ_LANES} = {1'b1, w, a, d, l};
    for (n = 0; n < 20 && REQ_READY !== 1'b1; n++) @(negedge SYS_CLK);
    check(n < 20);
    @(negedge SYS_CLK);
    REQ_VALID = 1'b0;
    for (n = 1; n < 20 && (w ? REQ_READY : RSP_VALID) !== 1'b1; n++) @(negedge SYS_CLK);
    check(n == (w ? 3 : 4));
    if (n == 20) conclude();
  endtask
  task automatic lanes();
    {REQ_VALID, REQ_LANES} = 3'b100;
    repeat (3) @(negedge SYS_CLK);
    check(SRAM_CS_N === 1'b1 && SRAM_WE_N === 1'b1 && REQ_READY === 1'b1);
    req(1'b1, 20'hFFFF3, 16'h1234, 2'h3);
    check(SRAM_ADDR === 20'hFFFF3);
    req(1'b1, 20'h00003, 16'hFFAB, 2'h1);
    req(1'b1, 20'h00003, 16'hCDFF, 2'h2);
    req(1'b0, 20'h00003, 16'h0000, 2'h1);
    check(RSP_RDATA === 16'h00AB);
  endtask
  task automatic retention();
    RETAIN_REQ = 1'b1;
    repeat (3) @(negedge SYS_CLK);
    check(RETAIN_SAFE === 1'b1 && SRAM_CS_N === 1'b1 && SRAM_CS_HI === 1'b0);
    SUPPLY_OK = 1'b0;
    repeat (3) @(negedge SYS_CLK);
    {SUPPLY_OK, RETAIN_REQ} = 2'b10;
    req(1'b0, 20'h00003, 16'h0000, 2'h3);
    check(RSP_RDATA === 16'hCDAB);
  endtask
  initial begin
    repeat (4) @(negedge SYS_CLK);
    RESET = 1'b0;
    lanes();
    retention();
    conclude();
  end
endmodule
bind sram_host sram_host_assertions sram_host_assertions_i (.*);
